// [core/ovhp_cfg.svh]
/*
 constants of the transmit overhead insert port: frame timing, field
 positions and sizes.
 assumes the link clock runs at 125 ns and the port clock is half of it.
*/
`ifndef OVHP_CFG_SVH
`define OVHP_CFG_SVH

// timing
`define OVHP_LINK_PERIOD_NS 125
`define OVHP_PCLK_DIV 2
`define OVHP_FRAME_NS 125000
`define OVHP_FRAME_CYC \
    (`OVHP_FRAME_NS / (`OVHP_LINK_PERIOD_NS * `OVHP_PCLK_DIV))

// overhead of the first sts-1: 9 rows of 3 bytes
`define OVHP_TOH_BYTES 27
`define OVHP_TOH_BITS (`OVHP_TOH_BYTES * 8)
`define OVHP_FIRST_STS 2'h0

// widths and field positions of a crossing word {idx, data, mask}
`define OVHP_CYC_W 9
`define OVHP_POS_W 8
`define OVHP_IDX_W 5
`define OVHP_WORD_W (`OVHP_IDX_W + 16)
`define OVHP_F_MASK_LSB 0
`define OVHP_F_DATA_LSB 8
`define OVHP_F_IDX_LSB 16
`define OVHP_FIFO_DEPTH 8

// reset values
`define OVHP_RST_CYC 9'h1f3
`define OVHP_RST_BYTE 8'h00

`endif

// [core/ovhp_pkg.sv]
/*
 types of the transmit overhead insert port.
 assumes ovhp_cfg.svh is on the include path.
*/
`include "ovhp_cfg.svh"

package ovhp_pkg;

    typedef enum logic [2:0] {
        OVHP_ST_MARK = 3'b001,
        OVHP_ST_OPEN = 3'b010,
        OVHP_ST_GAP  = 3'b100
    } ovhp_state_e;

    typedef logic [`OVHP_WORD_W-1:0] ovhp_word_t;

endpackage

// [core/ovhp_fifo.sv]
/*
 small fifo with a registered head slot, valid and ready on both sides.
 assumes one clock and an asynchronous active high reset.
*/
module ovhp_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // fill side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // drain side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
    logic [CW-1:0] cnt_q, cnt_d;
    logic [WIDTH-1:0] head_q, head_d;
    logic head_v_q, head_v_d;
    logic push, load;

    // head slot keeps read data in a register; it adds one entry
    always_comb begin
        push = i_valid && (cnt_q != FULL);
        load = (cnt_q != '0) && (!head_v_q || i_ready);
        wr_d = push ? ((wr_q == LAST) ? '0 : wr_q + 1'b1) : wr_q;
        rd_d = load ? ((rd_q == LAST) ? '0 : rd_q + 1'b1) : rd_q;
        cnt_d = cnt_q + CW'(push) - CW'(load);
        head_d = load ? mem[rd_q] : head_q;
        if (load) begin
            head_v_d = 1'b1;
        end else if (head_v_q && i_ready) begin
            head_v_d = 1'b0;
        end else begin
            head_v_d = head_v_q;
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_q] <= i_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            head_q <= '0;
            head_v_q <= 1'b0;
        end else begin
            wr_q <= wr_d;
            rd_q <= rd_d;
            cnt_q <= cnt_d;
            head_q <= head_d;
            head_v_q <= head_v_d;
        end
    end

    assign o_ready = (cnt_q != FULL);
    assign o_valid = head_v_q;
    assign o_data = head_q;

endmodule // ovhp_fifo

// [core/ovhp_tx_port.sv]
/*
 transmit overhead insert port: drives the port clock, frame mark and
 ready pins, captures serial overhead bits from outside and merges them
 into the first sts-1 of the internal overhead byte stream.
 assumes i_link_clk is free running at 125 ns, unrelated to i_sys_clk,
 and that the internal stream gives sts number and byte index per byte.
 a byte offered by the stream before its word has crossed goes out
 unchanged; the outside logic must launch bits on a port clock fall.
*/
// What this block does
// - drive a port clock out; all port transfers are timed by it.
// - capture serial bit on port clock rise when ready and insert high.
// - replace overhead only within the first sts-1, never the others.
// - hold ready high while the port can accept bits.
// - ignore serial input whenever ready or insert is low.
// - frame mark pulses one period, one period before first bit.
// - with insert low, nothing is sampled nor inserted.
`include "ovhp_cfg.svh"

module ovhp_tx_port
    import ovhp_pkg::*;
(
    // system clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // link clock
    input wire logic i_link_clk,
    // overhead port pins
    output logic o_ovh_port_clk_out,
    output logic o_ovh_port_ready_out,
    output logic o_ovh_port_frame_mark_out,
    input wire logic i_ovh_port_serial_in,
    input wire logic i_ovh_port_insert_en_in,
    // internal overhead stream in
    input wire logic i_ovh_valid,
    input wire logic [7:0] i_ovh_data,
    input wire logic [1:0] i_ovh_sts,
    input wire logic [`OVHP_IDX_W-1:0] i_ovh_idx,
    // merged overhead stream out
    output logic o_ovh_valid,
    output logic [7:0] o_ovh_data
);
    localparam logic [`OVHP_CYC_W-1:0] FRAME_LAST =
        `OVHP_CYC_W'(`OVHP_FRAME_CYC - 1);
    localparam logic [`OVHP_CYC_W-1:0] OPEN_LAST =
        `OVHP_CYC_W'(`OVHP_TOH_BITS);

    // link domain reset, released on the link clock
    logic lrst_a_q, lrst_q;

    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            lrst_a_q <= 1'b1;
            lrst_q <= 1'b1;
        end else begin
            lrst_a_q <= 1'b0;
            lrst_q <= lrst_a_q;
        end
    end

    // pin and ack synchronisers
    logic ser_s1_q, ser_s2_q, ins_s1_q, ins_s2_q, ack_s1_q, ack_s2_q;
    logic ack_q;

    always_ff @(posedge i_link_clk or posedge lrst_q) begin
        if (lrst_q) begin
            ser_s1_q <= 1'b0;
            ser_s2_q <= 1'b0;
            ins_s1_q <= 1'b0;
            ins_s2_q <= 1'b0;
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
        end else begin
            ser_s1_q <= i_ovh_port_serial_in;
            ser_s2_q <= ser_s1_q;
            ins_s1_q <= i_ovh_port_insert_en_in;
            ins_s2_q <= ins_s1_q;
            ack_s1_q <= ack_q;
            ack_s2_q <= ack_s1_q;
        end
    end

    // link side: port clock, frame counter and the pins they drive
    logic pclk_q, pclk_d;
    logic [`OVHP_CYC_W-1:0] cyc_q, cyc_d;
    ovhp_state_e state_q, state_d;
    logic ready_q, ready_d, frame_q, frame_d;
    logic rise, pend;

    // link side: bit capture and byte assembly
    logic smp_rdy_q, smp_rdy_d, smp_open_q, smp_open_d;
    logic [`OVHP_POS_W-1:0] smp_pos_q, smp_pos_d;
    logic [7:0] shift_q, shift_d, mask_q, mask_d;
    ovhp_word_t word_q, word_d;
    logic req_q, req_d, busy;
    logic [2:0] bit_sel;

    always_comb begin
        // the next link edge raises the port clock: a new port cycle opens
        rise = !pclk_q;
        pclk_d = !pclk_q;
        cyc_d = cyc_q;
        state_d = state_q;
        ready_d = ready_q;
        frame_d = frame_q;
        // a word still crossing blocks new bits rather than losing them
        pend = (req_d != ack_s2_q);
        if (rise) begin
            cyc_d = (cyc_q == FRAME_LAST) ? '0 : cyc_q + 1'b1;
            unique case (state_q)
                OVHP_ST_MARK: begin
                    state_d = OVHP_ST_OPEN;
                end
                OVHP_ST_OPEN: begin
                    if (cyc_d > OPEN_LAST) begin
                        state_d = OVHP_ST_GAP;
                    end
                end
                OVHP_ST_GAP: begin
                    if (cyc_d == '0) begin
                        state_d = OVHP_ST_MARK;
                    end
                end
            endcase
            frame_d = (state_d == OVHP_ST_MARK);
            ready_d = (state_d == OVHP_ST_OPEN) && !pend;
        end
    end

    always_ff @(posedge i_link_clk or posedge lrst_q) begin
        if (lrst_q) begin
            pclk_q <= 1'b0;
            cyc_q <= `OVHP_RST_CYC;
            state_q <= OVHP_ST_GAP;
            ready_q <= 1'b0;
            frame_q <= 1'b0;
        end else begin
            pclk_q <= pclk_d;
            cyc_q <= cyc_d;
            state_q <= state_d;
            ready_q <= ready_d;
            frame_q <= frame_d;
        end
    end

    always_comb begin
        smp_rdy_d = smp_rdy_q;
        smp_open_d = smp_open_q;
        smp_pos_d = smp_pos_q;
        shift_d = shift_q;
        mask_d = mask_q;
        word_d = word_q;
        req_d = req_q;
        busy = (req_q != ack_s2_q);
        bit_sel = 3'h7 - smp_pos_q[2:0];
        if (!pclk_q) begin
            // sync stage 2 holds the pins as they stood at the last rise,
            // so the capture trails that rise by one port period
            if (smp_open_q) begin
                if (smp_rdy_q && ins_s2_q) begin
                    shift_d[bit_sel] = ser_s2_q;
                    mask_d[bit_sel] = 1'b1;
                end
                if (smp_pos_q[2:0] == 3'h7) begin
                    // a byte ending while the last word still crosses is
                    // dropped, so the crossing word never moves under it
                    if (mask_d != `OVHP_RST_BYTE && !busy) begin
                        word_d = {smp_pos_q[7:3], shift_d, mask_d};
                        req_d = !req_q;
                    end
                    shift_d = `OVHP_RST_BYTE;
                    mask_d = `OVHP_RST_BYTE;
                end
            end
            // remember what the rise now taking place samples against
            smp_rdy_d = ready_q;
            smp_open_d = (state_q == OVHP_ST_OPEN);
            smp_pos_d = `OVHP_POS_W'(cyc_q - 1'b1);
        end
    end

    always_ff @(posedge i_link_clk or posedge lrst_q) begin
        if (lrst_q) begin
            smp_rdy_q <= 1'b0;
            smp_open_q <= 1'b0;
            smp_pos_q <= '0;
            shift_q <= `OVHP_RST_BYTE;
            mask_q <= `OVHP_RST_BYTE;
            word_q <= '0;
            req_q <= 1'b0;
        end else begin
            smp_rdy_q <= smp_rdy_d;
            smp_open_q <= smp_open_d;
            smp_pos_q <= smp_pos_d;
            shift_q <= shift_d;
            mask_q <= mask_d;
            word_q <= word_d;
            req_q <= req_d;
        end
    end

    assign o_ovh_port_clk_out = pclk_q;
    assign o_ovh_port_ready_out = ready_q;
    assign o_ovh_port_frame_mark_out = frame_q;

    // system side: word handshake into the fifo
    logic req_s1_q, req_s2_q, ack_d;
    logic new_word, f_in_rdy, f_valid, f_pop;
    ovhp_word_t f_word;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
        end else begin
            req_s1_q <= req_q;
            req_s2_q <= req_s1_q;
        end
    end

    // word_q stands still until the ack returns, so it is safe to read
    always_comb begin
        new_word = (req_s2_q != ack_q);
        ack_d = (new_word && f_in_rdy) ? req_s2_q : ack_q;
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
        end
    end

    ovhp_fifo #(
        .WIDTH(`OVHP_WORD_W),
        .DEPTH(`OVHP_FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_valid(new_word),
        .i_data(word_q),
        .o_ready(f_in_rdy),
        .o_valid(f_valid),
        .o_data(f_word),
        .i_ready(f_pop)
    );

    // merge into the internal stream
    logic [`OVHP_IDX_W-1:0] f_idx;
    logic [7:0] f_data, f_mask;
    logic hit, match, stale;
    logic out_valid_q, out_valid_d;
    logic [7:0] out_data_q, out_data_d;

    always_comb begin
        f_idx = f_word[`OVHP_F_IDX_LSB +: `OVHP_IDX_W];
        f_data = f_word[`OVHP_F_DATA_LSB +: 8];
        f_mask = f_word[`OVHP_F_MASK_LSB +: 8];
        hit = i_ovh_valid && (i_ovh_sts == `OVHP_FIRST_STS) && f_valid;
        match = hit && (f_idx == i_ovh_idx);
        // an entry whose byte has already gone by is dropped unused
        stale = hit && (f_idx < i_ovh_idx);
        f_pop = match || stale;
        out_valid_d = i_ovh_valid;
        out_data_d = i_ovh_data;
        if (match) begin
            out_data_d = (f_data & f_mask) | (i_ovh_data & ~f_mask);
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            out_valid_q <= 1'b0;
            out_data_q <= `OVHP_RST_BYTE;
        end else begin
            out_valid_q <= out_valid_d;
            out_data_q <= out_data_d;
        end
    end

    assign o_ovh_valid = out_valid_q;
    assign o_ovh_data = out_data_q;

endmodule // ovhp_tx_port

// [dv/ovhp_tx_port_sva.sv]
/* checker of the overhead port pins and of the merged byte stream.
   assumes it is bound to ovhp_tx_port and sees only its ports. */
module ovhp_tx_port_sva (
    // clocks and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_link_clk,
    // port pins
    input wire logic o_ovh_port_clk_out,
    input wire logic o_ovh_port_ready_out,
    input wire logic o_ovh_port_frame_mark_out,
    input wire logic i_ovh_port_insert_en_in,
    // stream
    input wire logic i_ovh_valid,
    input wire logic [7:0] i_ovh_data,
    input wire logic [1:0] i_ovh_sts,
    input wire logic o_ovh_valid,
    input wire logic [7:0] o_ovh_data
);
    wire logic pclk = o_ovh_port_clk_out;
    wire logic rdy = o_ovh_port_ready_out;
    wire logic mark = o_ovh_port_frame_mark_out;
    // link cycles since the last mark rise; a frame is 1000 of them
    logic [9:0] since_q, since_d;
    logic mark_q, seen_q, seen_d, ins_q, ins_d;
    always_comb begin
        since_d = (mark && !mark_q) ? 10'h000 : since_q + 10'h001;
        seen_d = seen_q | (mark && !mark_q);
        ins_d = ins_q | i_ovh_port_insert_en_in;
    end
    always_ff @(posedge i_link_clk or posedge i_rst) begin
        if (i_rst) begin
            since_q <= 10'h000;
            seen_q <= 1'b0;
            mark_q <= 1'b0;
        end else begin
            since_q <= since_d;
            seen_q <= seen_d;
            mark_q <= mark;
        end
    end
    // any insert request ever seen; stays set to keep the check simple
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ins_q <= 1'b0;
        end else begin
            ins_q <= ins_d;
        end
    end
    sequence s_mark_tail;
        mark ##1 !mark && rdy;
    endsequence
    a_pclk_toggle: assert property (
        @(posedge i_link_clk) disable iff (i_rst)
        $rose(pclk) |=> $fell(pclk) ##1 $rose(pclk))
        else $error("port clock not half the link clock");
    a_mark_width: assert property (
        @(posedge i_link_clk) disable iff (i_rst)
        $rose(mark) |=> s_mark_tail)
        else $error("frame mark not one port period");
    a_mark_spacing: assert property (
        @(posedge i_link_clk) disable iff (i_rst)
        mark && !mark_q && seen_q |-> since_q == 10'h3e7)
        else $error("frame mark spacing wrong");
    a_pins_on_rise: assert property (
        @(posedge i_link_clk) disable iff (i_rst)
        $changed({rdy, mark}) |-> $rose(pclk))
        else $error("ready or mark moved off a port clock rise");
    a_ready_window: assert property (
        @(posedge i_link_clk) disable iff (i_rst)
        rdy && seen_q |-> since_q >= 10'h001 && since_q <= 10'h1b0)
        else $error("ready outside the open window");
    a_stream_latency: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        1'b1 |=> o_ovh_valid == $past(i_ovh_valid))
        else $error("merged valid not one cycle late");
    a_other_sts: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        i_ovh_valid && i_ovh_sts != 2'h0 |=> o_ovh_data == $past(i_ovh_data))
        else $error("later sts byte altered");
    a_idle_kept: assert property (
        @(posedge i_sys_clk) disable iff (i_rst)
        i_ovh_valid && !ins_q |=> o_ovh_data == $past(i_ovh_data))
        else $error("byte altered with insert never enabled");
endmodule // ovhp_tx_port_sva

bind ovhp_tx_port ovhp_tx_port_sva ovhp_tx_port_sva_inst (
    .i_sys_clk, .i_rst, .i_link_clk, .o_ovh_port_clk_out,
    .o_ovh_port_ready_out, .o_ovh_port_frame_mark_out,
    .i_ovh_port_insert_en_in, .i_ovh_valid, .i_ovh_data, .i_ovh_sts,
    .o_ovh_valid, .o_ovh_data
);

// [dv/ovhp_ext_model.sv]
/* behavioural model of the outside logic feeding overhead bits.
   assumes the port clock, ready and mark pins of the insert port. */
module ovhp_ext_model (
    // port pins
    input wire logic i_pclk,
    input wire logic i_ready,
    input wire logic i_mark,
    output logic o_insert,
    output logic o_serial,
    // scenario control
    input wire logic i_en,
    input wire logic [7:0] i_pat,
    input wire logic [3:0] i_nbits
);
    timeunit 1ns;
    timeprecision 100ps;
    logic armed = 1'b0;
    logic [3:0] sent = 4'h0;
    initial begin
        o_insert = 1'b0;
        o_serial = 1'b0;
    end
    // pins looked at mid-cycle, away from the rise that moves them
    always @(negedge i_pclk) begin
        if (i_mark) begin
            armed = i_en;
            sent = 4'h0;
        end
        if (armed && i_ready && sent < i_nbits) begin
            o_insert <= 1'b1;
            o_serial <= i_pat[3'h7 - sent[2:0]];
            sent = sent + 4'h1;
        end else begin
            o_insert <= 1'b0;
            o_serial <= ~o_serial; // no stale bit left on the line
        end
    end
endmodule // ovhp_ext_model

// [dv/tb_top.sv]
/* self-checking bench of the overhead insert port.
   assumes the design, its checker and the outside model compile first. */
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_sys_clk = 1'b0;
    logic i_link_clk = 1'b0;
    logic i_rst = 1'b1;
    logic o_ovh_port_clk_out, o_ovh_port_ready_out, o_ovh_port_frame_mark_out;
    logic i_ovh_port_serial_in, i_ovh_port_insert_en_in, o_ovh_valid;
    logic i_ovh_valid = 1'b0;
    logic [7:0] i_ovh_data = 8'h00;
    logic [1:0] i_ovh_sts = 2'h0;
    logic [4:0] i_ovh_idx = 5'h00;
    logic [7:0] o_ovh_data;
    logic en = 1'b0;
    logic [7:0] pat = 8'h00;
    logic [3:0] nbits = 4'h0;
    int errors = 0;
    int checks_done = 0;
    int cycles = 0;
    always #25 i_sys_clk = ~i_sys_clk;
    initial begin
        #7.3;
        forever #62.5 i_link_clk = ~i_link_clk;
    end
    ovhp_tx_port ovhp_tx_port_inst (
        .i_sys_clk, .i_rst, .i_link_clk, .o_ovh_port_clk_out,
        .o_ovh_port_ready_out, .o_ovh_port_frame_mark_out,
        .i_ovh_port_serial_in, .i_ovh_port_insert_en_in, .i_ovh_valid,
        .i_ovh_data, .i_ovh_sts, .i_ovh_idx, .o_ovh_valid, .o_ovh_data
    );
    ovhp_ext_model ovhp_ext_model_inst (
        .i_pclk(o_ovh_port_clk_out), .i_ready(o_ovh_port_ready_out),
        .i_mark(o_ovh_port_frame_mark_out), .o_insert(i_ovh_port_insert_en_in),
        .o_serial(i_ovh_port_serial_in), .i_en(en), .i_pat(pat),
        .i_nbits(nbits)
    );
    task automatic check(input logic [7:0] seen, exp, input string msg);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s %h not %h", $time, msg, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic send(input logic [1:0] sts, input logic [4:0] idx,
                        input logic [7:0] din, exp);
        @(posedge i_sys_clk) #2;
        i_ovh_valid = 1'b1;
        i_ovh_sts = sts;
        i_ovh_idx = idx;
        i_ovh_data = din;
        @(posedge i_sys_clk) #2;
        i_ovh_valid = 1'b0;
        check({7'h00, o_ovh_valid}, 8'h01, "merged valid");
        check(o_ovh_data, exp, "merged byte");
    endtask
    task automatic wait_mark();
        int n;
        n = 0;
        while (o_ovh_port_frame_mark_out !== 1'b1 && n < 3000) begin
            @(posedge i_sys_clk);
            n++;
        end
        check({7'h00, n < 3000}, 8'h01, "frame mark");
        repeat (10) @(posedge i_sys_clk);
    endtask
    // a fixed wait: the crossing has no completion seen at the pins
    task automatic insert_frame(input logic [7:0] p, input logic [3:0] nb);
        en = 1'b1;
        pat = p;
        nbits = nb;
        wait_mark();
        repeat (200) @(posedge i_sys_clk);
        #2 en = 1'b0;
    endtask
    task automatic t_reset();
        #2;
        check({5'h00, o_ovh_port_clk_out, o_ovh_port_ready_out,
               o_ovh_port_frame_mark_out}, 8'h00, "pins in reset");
        check({7'h00, o_ovh_valid}, 8'h00, "valid in reset");
        i_rst = 1'b0;
        $display("test reset done");
    endtask
    task automatic t_idle();
        send(2'h0, 5'h02, 8'h77, 8'h77);
        $display("test idle done");
    endtask
    task automatic t_full_byte();
        insert_frame(8'ha5, 4'h8);
        send(2'h1, 5'h00, 8'h3c, 8'h3c);
        send(2'h0, 5'h00, 8'h3c, 8'ha5);
        send(2'h0, 5'h00, 8'h3c, 8'h3c);
        $display("test full byte done");
    endtask
    task automatic t_half_byte();
        insert_frame(8'ha5, 4'h4);
        send(2'h0, 5'h00, 8'h0f, 8'haf);
        send(2'h0, 5'h01, 8'h5a, 8'h5a);
        $display("test half byte done");
    endtask
    task automatic t_disabled();
        wait_mark();
        repeat (200) @(posedge i_sys_clk);
        send(2'h0, 5'h00, 8'h11, 8'h11);
        $display("test disabled done");
    endtask
    // just over two frames of 2500 cycles are needed; the ceiling is about four times that
    always @(posedge i_sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            end_of_test();
        end
    end
    // reset kept longer than five cycles so the link side sees two edges
    initial begin
        repeat (6) @(posedge i_sys_clk);
        t_reset();
        t_idle();
        t_full_byte();
        t_half_byte();
        t_disabled();
        end_of_test();
    end
endmodule // tb_top
